/* File: src/gdc_pkg.sv */
// Shared types and timing constants for the gate driver host controller.
// Assumes a single 25 MHz clock; all counts are derived from it.
package gdc_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_NS          = 40;
	localparam int DEGLITCH_NS     = 40;
	localparam int FAULT_MUTE_NS   = 2000;
	localparam int RESET_FILTER_NS = 1000;
	localparam int SETTLE_NS       = 200;
	// Strictly longer than the deglitch window, so one cycle of margin
	localparam int DEGLITCH_CYC    = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS + 1;
	localparam int FAULT_MUTE_CYC  = (FAULT_MUTE_NS + CLK_NS - 1) / CLK_NS;
	// Low level must exceed the filter time and survive the deglitch
	localparam int RESET_LOW_CYC   = RESET_FILTER_NS / CLK_NS + 1 + DEGLITCH_CYC;
	localparam int SETTLE_CYC      = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W           = 16;

	// ----------------------------------------------------------------
	// Drive modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		GDC_MODE_NONINV = 2'h0,
		GDC_MODE_INV    = 2'h1
	} gdc_mode_type;

	// ----------------------------------------------------------------
	// Fault handling states
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		GDC_ST_RUN     = 5'h01,
		GDC_ST_MUTE    = 5'h02,
		GDC_ST_WAIT    = 5'h04,
		GDC_ST_PULSE   = 5'h08,
		GDC_ST_RELEASE = 5'h10
	} gdc_state_type;

	// ----------------------------------------------------------------
	// Pins driven toward the driver
	// ----------------------------------------------------------------
	typedef struct packed {
		logic in_pos;
		logic in_neg;
		logic reset_enable_low;
	} gdc_pins_type;

	// Reporting lines read back from the driver (open drain, pulled up on the board)
	typedef struct packed {
		logic fault_report_n;
		logic power_good;
	} gdc_report_type;

endpackage : gdc_pkg

/* File: src/gdc_min_width.sv */
// Per-bit minimum level-hold filter for the PWM request lines.
// Assumes requests are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module gdc_min_width #(
	parameter int WIDTH   = 2,
	parameter int MIN_CYC = gdc_pkg::DEGLITCH_CYC
) (
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] req,
	output var  logic [WIDTH-1:0] held
);

	// ----------------------------------------------------------------
	// Hold each level long enough to pass the input deglitch
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
			logic [gdc_pkg::CNT_W-1:0] age;
			always_ff @(posedge mclk) begin
				if (!resetn) begin
					held[gi] <= 1'b0;
					age      <= '0;
				end else if (req[gi] != held[gi] && age >= gdc_pkg::CNT_W'(MIN_CYC - 1)) begin
					held[gi] <= req[gi];
					age      <= '0;
				end else if (age != {gdc_pkg::CNT_W{1'b1}}) begin
					age <= age + 1'b1;
				end
			end
		end
	endgenerate

endmodule : gdc_min_width
`default_nettype wire

/* File: src/gdc_host_ctrl.sv */
// Host-side controller for an isolated single-channel gate driver.
// Assumes report lines are pulled up on the board and synchronous to mclk.
// Function
// - Host never floats inputs; unused inverting grounded.
// - Report outputs open drain; board pulls up.
// - Host drives reset/enable high to enable.
// - Host reset only after fault mute time; only the manual PULSE waits for it, auto reset follows PWM through mute.
// - Non-inverting auto reset follows PWM input.
// - Inverting auto reset uses inverted PWM.
`timescale 1ns/1ps
`default_nettype none
module gdc_host_ctrl #(
	parameter int MUTE_CYC   = gdc_pkg::FAULT_MUTE_CYC,
	parameter int RESET_CYC  = gdc_pkg::RESET_LOW_CYC,
	parameter int SETTLE_CYC = gdc_pkg::SETTLE_CYC
) (
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	input  wire logic                  pwm_req,
	input  wire logic                  other_leg_pwm,
	input  wire logic                  use_interlock,
	input  wire gdc_pkg::gdc_mode_type mode,
	input  wire logic                  auto_reset,
	input  wire logic                  enable_req,
	input  wire logic                  fault_clear_req,
	input  wire gdc_pkg::gdc_report_type report,
	output var  gdc_pkg::gdc_pins_type   pins,
	output var  logic                  fault_seen,
	output logic                       fault_event,
	output var  logic                  undervoltage_lockout,
	output logic                       busy
);

	gdc_pkg::gdc_state_type    state;
	gdc_pkg::gdc_state_type    next_state;
	logic [gdc_pkg::CNT_W-1:0] count;
	logic                      fault_prev;
	logic                      count_done;
	logic                      run_ok;
	logic                      req_pos;
	logic                      req_neg;
	logic [1:0]                held;
	logic                      next_rst;

	assign count_done  = (count == '0);
	assign fault_event = !report.fault_report_n && fault_prev;
	assign busy        = (state != gdc_pkg::GDC_ST_RUN);
	assign run_ok      = enable_req && (state == gdc_pkg::GDC_ST_RUN || auto_reset);

	// ----------------------------------------------------------------
	// PWM request shaping
	// ----------------------------------------------------------------
	always_comb begin
		req_pos = 1'b0;
		req_neg = 1'b0;
		if (run_ok) begin
			if (mode == gdc_pkg::GDC_MODE_INV) begin
				req_pos = 1'b1;
				req_neg = !pwm_req;
			end else begin
				req_pos = pwm_req;
				req_neg = use_interlock && other_leg_pwm;
			end
		end
	end

	gdc_min_width #(
		.WIDTH   (2),
		.MIN_CYC (gdc_pkg::DEGLITCH_CYC)
	) u_width (
		.mclk   (mclk),
		.resetn (resetn),
		.req    ({req_pos, req_neg}),
		.held   (held)
	);

	// ----------------------------------------------------------------
	// Reset/enable level
	// ----------------------------------------------------------------
	always_comb begin
		next_rst = 1'b0;
		if (auto_reset) begin
			next_rst = (mode == gdc_pkg::GDC_MODE_INV) ? !held[0] : held[1];
			next_rst = next_rst && enable_req;
		end else begin
			case (state)
				gdc_pkg::GDC_ST_PULSE: next_rst = 1'b0;
				default:               next_rst = enable_req;
			endcase
		end
	end

	// Pins always driven, never floating
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pins <= '0;
		end else begin
			pins.in_pos           <= held[1];
			pins.in_neg           <= held[0];
			pins.reset_enable_low <= next_rst;
		end
	end

	// ----------------------------------------------------------------
	// Report capture
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			fault_prev           <= 1'b1;
			undervoltage_lockout <= 1'b0;
		end else begin
			fault_prev           <= report.fault_report_n;
			undervoltage_lockout <= !report.power_good;
		end
	end

	// Set wins over clear
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			fault_seen <= 1'b0;
		end else if (!report.fault_report_n) begin
			fault_seen <= 1'b1;
		end else if (state == gdc_pkg::GDC_ST_RUN) begin
			fault_seen <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Manual fault recovery
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			gdc_pkg::GDC_ST_RUN:
				if (fault_event && !auto_reset) begin
					next_state = gdc_pkg::GDC_ST_MUTE;
				end
			gdc_pkg::GDC_ST_MUTE:
				if (count_done) begin
					next_state = gdc_pkg::GDC_ST_WAIT;
				end
			gdc_pkg::GDC_ST_WAIT:
				if (fault_clear_req) begin
					next_state = gdc_pkg::GDC_ST_PULSE;
				end
			gdc_pkg::GDC_ST_PULSE:
				if (count_done) begin
					next_state = gdc_pkg::GDC_ST_RELEASE;
				end
			gdc_pkg::GDC_ST_RELEASE:
				if (count_done) begin
					next_state = report.fault_report_n ? gdc_pkg::GDC_ST_RUN
					                                   : gdc_pkg::GDC_ST_WAIT;
				end
			default:
				next_state = gdc_pkg::GDC_ST_RUN;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state <= gdc_pkg::GDC_ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Counter reloads on each state entry
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			count <= '0;
		end else if (next_state != state) begin
			case (next_state)
				gdc_pkg::GDC_ST_MUTE:    count <= gdc_pkg::CNT_W'(MUTE_CYC - 1);
				gdc_pkg::GDC_ST_PULSE:   count <= gdc_pkg::CNT_W'(RESET_CYC - 1);
				gdc_pkg::GDC_ST_RELEASE: count <= gdc_pkg::CNT_W'(SETTLE_CYC - 1);
				default:                 count <= '0;
			endcase
		end else if (!count_done) begin
			count <= count - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [gdc_pkg::CNT_W-1:0] mute_age;
	always_ff @(posedge mclk) begin
		if (!resetn || state == gdc_pkg::GDC_ST_RUN) begin
			mute_age <= '0;
		end else if (mute_age != {gdc_pkg::CNT_W{1'b1}}) begin
			mute_age <= mute_age + 1'b1;
		end
	end

	sequence pulse_entry_s;
		state == gdc_pkg::GDC_ST_WAIT && fault_clear_req;
	endsequence

	sequence pulse_low_s;
		!pins.reset_enable_low [*2];
	endsequence

	// Hold filter may keep the old level one extra cycle
	ground_unused_a: assert property (@(posedge mclk) disable iff (!resetn)
		$past(mode == gdc_pkg::GDC_MODE_NONINV && !use_interlock, 2)
		&& $past(mode == gdc_pkg::GDC_MODE_NONINV && !use_interlock, 3) && $past(resetn, 3)
		|-> !pins.in_neg)
		else $error("Unused inverting input not grounded");

	enable_level_a: assert property (@(posedge mclk) disable iff (!resetn)
		!enable_req |=> !pins.reset_enable_low)
		else $error("Reset/enable high while disabled");

	mute_respected_a: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(state == gdc_pkg::GDC_ST_PULSE) |-> mute_age >= gdc_pkg::CNT_W'(MUTE_CYC + 1))
		else $error("Reset pulse issued inside mute time");

	pulse_held_a: assert property (@(posedge mclk) disable iff (!resetn)
		pulse_entry_s ##1 1'b1 |=> pulse_low_s)
		else $error("Reset pulse too short");

	auto_pos_a: assert property (@(posedge mclk) disable iff (!resetn)
		$past(resetn && auto_reset && enable_req && mode == gdc_pkg::GDC_MODE_NONINV)
		|-> pins.reset_enable_low == pins.in_pos)
		else $error("Auto reset does not follow non-inverting PWM");

	auto_neg_a: assert property (@(posedge mclk) disable iff (!resetn)
		$past(resetn && auto_reset && enable_req && mode == gdc_pkg::GDC_MODE_INV)
		|-> pins.reset_enable_low == !pins.in_neg)
		else $error("Auto reset not inverse of inverting PWM");

	fault_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
		!report.fault_report_n |=> fault_seen)
		else $error("Fault report not captured");

	fault_stop_a: assert property (@(posedge mclk) disable iff (!resetn)
		fault_event && !auto_reset |=> ##3 !pins.in_pos [*3])
		else $error("PWM not stopped after fault");

endmodule : gdc_host_ctrl
`default_nettype wire

/* File: bench/gdc_driver_model.sv */
// Behavioural gate driver on the far side of the control pins.
// Assumes pins are sampled on mclk; report lines read as board pull-ups.
`timescale 1ns/1ps
`default_nettype none
module gdc_driver_model #(
	parameter int MUTE_CYC   = 3,
	parameter int FILTER_CYC = 2,
	parameter int BLANK_CYC  = 5,
	parameter int MIN_CYC    = 2
) (
	input  wire logic                    mclk,
	input  wire gdc_pkg::gdc_pins_type   pins,
	input  wire logic                    desaturation_sense,
	input  wire logic                    supply_lost,
	output var  gdc_pkg::gdc_report_type report,
	output var  logic                    gate_output,
	output var  logic                    soft_off,
	output var  int                      short_pulses
);
	logic       fault_latched = 1'b0;
	logic       en_prev       = 1'b0;
	logic [2:0] pins_prev     = 3'h0;
	int         mute_cnt      = 0;
	int         low_cnt       = 0;
	int         blank_cnt     = 0;
	int         hold_cnt [3]  = '{default: MIN_CYC};

	initial soft_off = 1'b0;
	initial short_pulses = 0;

	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	// output gating
	always_comb begin
		gate_output = pins.reset_enable_low && pins.in_pos && !pins.in_neg
			&& !fault_latched && !supply_lost;
		report.fault_report_n = !fault_latched;
		report.power_good     = !supply_lost;
	end

	// ----------------------------------------------------------------
	// Fault latch
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		blank_cnt <= gate_output ? blank_cnt + 1 : 0;
		if (!fault_latched && desaturation_sense && blank_cnt >= BLANK_CYC) begin
			fault_latched <= 1'b1;
			soft_off      <= 1'b1;
			mute_cnt      <= MUTE_CYC;
		end else if (mute_cnt > 0) begin
			mute_cnt <= mute_cnt - 1;
		end
		low_cnt <= (!pins.reset_enable_low && mute_cnt == 0) ? low_cnt + 1 : 0;
		if (fault_latched && pins.reset_enable_low && !en_prev && low_cnt > FILTER_CYC) begin
			fault_latched <= 1'b0;
			soft_off      <= 1'b0;
		end
		en_prev <= pins.reset_enable_low;
	end

	// ----------------------------------------------------------------
	// Input deglitch watch
	// ----------------------------------------------------------------
	// levels must outlast deglitch
	always @(posedge mclk) begin
		for (int i = 0; i < 3; i++) begin
			if (pins[i] != pins_prev[i]) begin
				if (hold_cnt[i] < MIN_CYC)
					short_pulses <= short_pulses + 1;
				hold_cnt[i] <= 1;
			end else begin
				hold_cnt[i] <= hold_cnt[i] + 1;
			end
		end
		pins_prev <= pins;
	end
endmodule : gdc_driver_model
`default_nettype wire

/* File: bench/gdc_host_ctrl_test.sv */
// Self-checking bench for the gate driver host controller.
// Assumes the behavioural driver model answers on the pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("mismatch at %0t ns: %s", $time, msg); end end
module gdc_host_ctrl_test;
	typedef struct packed {
		logic inv, il, oth, pwm, en, ar, gate;
	} gdc_row_type;
	logic                    mclk = 1'b0;
	logic                    resetn = 1'b0;
	logic                    pwm_req = 1'b0;
	logic                    other_leg_pwm = 1'b0;
	logic                    use_interlock = 1'b0;
	gdc_pkg::gdc_mode_type   mode = gdc_pkg::GDC_MODE_NONINV;
	logic                    auto_reset = 1'b0;
	logic                    enable_req = 1'b0;
	logic                    fault_clear_req = 1'b0;
	logic                    desaturation_sense = 1'b0;
	logic                    supply_lost = 1'b0;
	gdc_pkg::gdc_report_type report;
	gdc_pkg::gdc_pins_type   pins;
	logic                    fault_seen, fault_event, undervoltage_lockout, busy;
	logic                    gate_output, soft_off;
	int                      short_pulses;
	int                      n_mismatch = 0;
	int                      compares = 0;
	gdc_row_type             rows [12] = '{
		'{0,0,0,1,1,0,1}, '{0,0,0,0,1,0,0}, '{0,1,1,1,1,0,0}, '{0,1,0,1,1,0,1},
		'{0,0,1,1,1,0,1}, '{0,0,0,1,0,0,0}, '{1,0,0,1,1,0,1}, '{1,0,0,0,1,0,0},
		'{1,0,0,1,0,0,0}, '{0,0,0,1,1,1,1}, '{1,0,0,1,1,1,1}, '{1,0,0,0,1,1,0}};

	always #20 mclk = ~mclk;

	// Settle must outlast pin register plus driver clear latency
	gdc_host_ctrl #(.MUTE_CYC(4), .RESET_CYC(4), .SETTLE_CYC(4)) gdc_host_ctrl_i (
		.mclk(mclk), .resetn(resetn), .pwm_req(pwm_req), .other_leg_pwm(other_leg_pwm),
		.use_interlock(use_interlock), .mode(mode), .auto_reset(auto_reset),
		.enable_req(enable_req), .fault_clear_req(fault_clear_req), .report(report),
		.pins(pins), .fault_seen(fault_seen), .fault_event(fault_event),
		.undervoltage_lockout(undervoltage_lockout), .busy(busy));

	gdc_driver_model gdc_driver_model_i (
		.mclk(mclk), .pins(pins), .desaturation_sense(desaturation_sense),
		.supply_lost(supply_lost), .report(report), .gate_output(gate_output),
		.soft_off(soft_off), .short_pulses(short_pulses));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic look(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask : look

	task automatic trip();
		@(posedge mclk);
		desaturation_sense <= 1'b1;
		for (int i = 0; i < 20 && report.fault_report_n !== 1'b0; i++)
			@(negedge mclk);
		`CHK(fault_event, 1'b1, "no fault event")
		`CHK(soft_off, 1'b1, "no soft turn-off")
		@(posedge mclk);
		desaturation_sense <= 1'b0;
	endtask : trip

	task automatic auto_trip(input logic inv);
		@(posedge mclk);
		mode       <= inv ? gdc_pkg::GDC_MODE_INV : gdc_pkg::GDC_MODE_NONINV;
		auto_reset <= 1'b1;
		pwm_req    <= 1'b1;
		look(8);
		trip();
		look(2);
		`CHK(gate_output, 1'b0, "gate on while faulted")
		`CHK({busy, fault_seen}, 2'h1, "auto fault flags")
		@(posedge mclk);
		pwm_req <= 1'b0;
		look(12);
		@(posedge mclk);
		pwm_req <= 1'b1;
		look(6);
		`CHK({report.fault_report_n, gate_output}, 2'h3, "auto reset failed")
	endtask : auto_trip

	task automatic complete_run();
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (11) @(posedge mclk);
		@(negedge mclk);
		`CHK(pins, 3'h0, "pins active in reset")
		`CHK({busy, fault_seen, undervoltage_lockout}, 3'h0, "flags in reset")
		@(posedge mclk);
		resetn <= 1'b1;
		foreach (rows[i]) begin
			@(posedge mclk);
			mode          <= rows[i].inv ? gdc_pkg::GDC_MODE_INV : gdc_pkg::GDC_MODE_NONINV;
			use_interlock <= rows[i].il;
			other_leg_pwm <= rows[i].oth;
			pwm_req       <= rows[i].pwm;
			enable_req    <= rows[i].en;
			auto_reset    <= rows[i].ar;
			look(6);
			`CHK(gate_output, rows[i].gate, "gate level")
		end
		@(posedge mclk);
		mode       <= gdc_pkg::GDC_MODE_NONINV;
		auto_reset <= 1'b0;
		pwm_req    <= 1'b1;
		@(posedge mclk);
		pwm_req <= 1'b0;
		look(6);
		`CHK(gate_output, 1'b0, "gate left on")
		@(posedge mclk);
		pwm_req            <= 1'b1;
		desaturation_sense <= 1'b1;
		look(3);
		`CHK(report.fault_report_n, 1'b1, "fault inside blanking")
		trip();
		fault_clear_req <= 1'b1;
		@(posedge mclk);
		fault_clear_req <= 1'b0;
		look(2);
		`CHK(pins.reset_enable_low, 1'b1, "clear taken in mute")
		`CHK({pins.in_pos, fault_seen, busy}, 3'h3, "fault state pins")
		look(6);
		`CHK(report.fault_report_n, 1'b0, "fault not latched")
		@(posedge mclk);
		fault_clear_req <= 1'b1;
		@(posedge mclk);
		fault_clear_req <= 1'b0;
		for (int i = 0; i < 60 && busy !== 1'b0; i++)
			@(negedge mclk);
		look(6);
		`CHK({report.fault_report_n, fault_seen, gate_output}, 3'h5, "no recovery")
		@(posedge mclk);
		supply_lost <= 1'b1;
		look(3);
		`CHK({undervoltage_lockout, gate_output}, 2'h2, "lockout entry")
		@(posedge mclk);
		supply_lost <= 1'b0;
		look(3);
		`CHK({undervoltage_lockout, gate_output, busy}, 3'h2, "lockout exit")
		auto_trip(1'b0);
		auto_trip(1'b1);
		@(posedge mclk);
		resetn <= 1'b0;
		look(1);
		`CHK({pins, gate_output}, 4'h0, "pins active in mid-run reset")
		`CHK({busy, fault_seen}, 2'h0, "flags after mid-run reset")
		@(posedge mclk);
		resetn <= 1'b1;
		look(6);
		`CHK(gate_output, 1'b1, "no restart after reset")
		`CHK(short_pulses, 0, "pin pulse too short")
		complete_run();
	end

	initial begin
		#200000;
		n_mismatch++;
		$display("mismatch at %0t ns: timeout", $time);
		complete_run();
	end
endmodule : gdc_host_ctrl_test
`default_nettype wire
